//--- include/lai_pkg.sv
package lai_pkg;
    localparam int CLK_HZ = 40_000_000;
    // button hold thresholds and debounce
    localparam int HOLD_MID_S = 5;
    localparam int HOLD_LONG_S = 10;
    localparam int HOLD_MID_CYC = HOLD_MID_S * CLK_HZ;
    localparam int HOLD_LONG_CYC = HOLD_LONG_S * CLK_HZ;
    localparam int DEBOUNCE_MS = 10;
    localparam int DEBOUNCE_CYC = DEBOUNCE_MS * (CLK_HZ / 1000);
    // lamp timing
    localparam int BLINK_MS = 125;
    localparam int BLINK_CYC = BLINK_MS * (CLK_HZ / 1000);
    localparam int PULSE_MS = 250;
    localparam int PULSE_CYC = PULSE_MS * (CLK_HZ / 1000);
    localparam int IDLE_STEP_S = 30;
    localparam int IDLE_STEP_CYC = IDLE_STEP_S * CLK_HZ;
    localparam logic [2:0] ZERO_FLASHES = 3'h3;
    // register map
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_ZERO = 8'h08;
    localparam logic [7:0] REG_LEAK = 8'h0c;
    localparam logic CTRL_RESET = 1'b0;
    localparam int CTRL_OPT_BIT = 0;
    localparam int ST_PUMP = 0;
    localparam int ST_ALARM = 1;
    localparam int ST_ALARM_MUTE = 2;
    localparam int ST_DRY = 3;
    localparam int ST_DRY_MUTE = 4;
    localparam int ST_TEST = 5;
    localparam int ST_ZERO_LOCK = 6;
    localparam int ST_ZERO_ARMED = 7;
    localparam int ST_REFILL_OK = 8;
    localparam int ST_FAULT = 9;
    localparam int LEAK_VALID_BIT = 2;

    typedef struct packed {
        logic humid;
        logic fault;
        logic gt_clear;
        logic le_alarm;
        logic ge_stop;
        logic le_start;
    } lai_sense_type;

    typedef enum logic [1:0] {
        ZERO_IDLE = 2'b00,
        ZERO_ARMED = 2'b01,
        ZERO_LOCKED = 2'b10
    } lai_zero_type;
endpackage

//--- logic/lai_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

module lai_ctrl
    import lai_pkg::*;
#(
    parameter int P_HOLD_MID = HOLD_MID_CYC,
    parameter int P_HOLD_LONG = HOLD_LONG_CYC,
    parameter int P_DEBOUNCE = DEBOUNCE_CYC,
    parameter int P_BLINK = BLINK_CYC,
    parameter int P_PULSE = PULSE_CYC,
    parameter int P_IDLE_STEP = IDLE_STEP_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // sensors and button
    input wire lai_sense_type sense,
    input wire logic [11:0] zero_level,
    input wire logic button_n,
    // actuators and indicators
    output logic pump_on,
    output logic op_lamp,
    output logic alarm_lamp,
    output logic dry_lamp,
    output logic buzzer,
    output logic remote_alarm,
    output logic dry_relay
);
    function automatic logic addr_ok(input logic [7:0] a);
        addr_ok = (a == REG_CTRL) || (a == REG_STATUS) || (a == REG_ZERO) || (a == REG_LEAK);
    endfunction

    lai_sense_type sense_s1_reg, s;
    logic [11:0] zero_s1_reg, zero_s2_reg, zero_point_reg;
    logic btn_s1_reg, btn_s2_reg, btn_deb_reg, btn_q_reg;
    logic [31:0] deb_cnt_reg, hold_cnt_reg, blink_cnt_reg, fl_tmr_reg, step_tmr_reg;
    logic [1:0] blink_div_reg, step_lvl_reg, leak_lvl_reg;
    logic fast_reg, slow_reg;
    logic pump_reg, pump_q_reg, alarm_reg, alarm_mute_reg, test_reg;
    logic dry_msg_reg, dry_mute_reg, dry_clr_reg, refill_ok_reg, ctrl_opt_reg;
    lai_zero_type zst_reg;
    logic [2:0] fl_cnt_reg;
    logic fl_on_reg, fl_buzz_reg;
    logic fall, short_rel, mid_rel, held_mid, long_hit, dry_clear, pump_rise;
    logic zero_take, leak_ask, fl_load, fl_active;
    logic [2:0] fl_n;
    logic alarm_lamp_next, dry_lamp_next, buzzer_next;
    logic [31:0] status;

    // two-stage synchronisers; only stage two is read
    always_ff @(posedge clk) begin
        if (rst) begin
            sense_s1_reg <= '0;
            s <= '0;
            zero_s1_reg <= 12'h000;
            zero_s2_reg <= 12'h000;
            btn_s1_reg <= 1'b1;
            btn_s2_reg <= 1'b1;
        end else begin
            sense_s1_reg <= sense;
            s <= sense_s1_reg;
            zero_s1_reg <= zero_level;
            zero_s2_reg <= zero_s1_reg;
            btn_s1_reg <= button_n;
            btn_s2_reg <= btn_s1_reg;
        end
    end

    // debounce: level must stay different for the whole window
    always_ff @(posedge clk) begin
        if (rst) begin
            deb_cnt_reg <= 32'h0;
            btn_deb_reg <= 1'b0;
            btn_q_reg <= 1'b0;
        end else begin
            btn_q_reg <= btn_deb_reg;
            if (btn_deb_reg == btn_s2_reg) begin
                if (deb_cnt_reg == 32'(P_DEBOUNCE - 1)) begin
                    deb_cnt_reg <= 32'h0;
                    btn_deb_reg <= ~btn_s2_reg;
                end else begin
                    deb_cnt_reg <= deb_cnt_reg + 32'h1;
                end
            end else begin
                deb_cnt_reg <= 32'h0;
            end
        end
    end

    // hold length, saturating at the long threshold
    always_ff @(posedge clk) begin
        if (rst || !btn_deb_reg) begin
            hold_cnt_reg <= 32'h0;
        end else if (hold_cnt_reg != 32'(P_HOLD_LONG)) begin
            hold_cnt_reg <= hold_cnt_reg + 32'h1;
        end
    end

    assign fall = btn_q_reg && !btn_deb_reg;
    assign short_rel = fall && (hold_cnt_reg < 32'(P_HOLD_MID));
    assign mid_rel = fall && (hold_cnt_reg >= 32'(P_HOLD_MID))
                     && (hold_cnt_reg < 32'(P_HOLD_LONG));
    assign held_mid = btn_deb_reg && (hold_cnt_reg >= 32'(P_HOLD_MID));
    assign long_hit = btn_deb_reg && (hold_cnt_reg == 32'(P_HOLD_LONG - 1));
    assign dry_clear = mid_rel && dry_msg_reg && !s.fault;
    assign pump_rise = pump_reg && !pump_q_reg;

    // blink base: fast phase toggles every period, slow every fourth
    always_ff @(posedge clk) begin
        if (rst) begin
            blink_cnt_reg <= 32'h0;
            blink_div_reg <= 2'h0;
            fast_reg <= 1'b0;
            slow_reg <= 1'b0;
        end else if (blink_cnt_reg == 32'(P_BLINK - 1)) begin
            blink_cnt_reg <= 32'h0;
            fast_reg <= ~fast_reg;
            blink_div_reg <= blink_div_reg + 2'h1;
            if (blink_div_reg == 2'h3) begin
                slow_reg <= ~slow_reg;
            end
        end else begin
            blink_cnt_reg <= blink_cnt_reg + 32'h1;
        end
    end

    // refill pump; stop threshold has priority
    always_ff @(posedge clk) begin
        if (rst) begin
            pump_reg <= 1'b0;
            pump_q_reg <= 1'b0;
        end else begin
            pump_q_reg <= pump_reg;
            if (s.ge_stop) begin
                pump_reg <= 1'b0;
            end else if (s.le_start) begin
                pump_reg <= 1'b1;
            end
        end
    end

    // container alarm with hysteresis up to the alarm-clear level
    always_ff @(posedge clk) begin
        if (rst) begin
            alarm_reg <= 1'b0;
        end else if (s.le_alarm) begin
            alarm_reg <= 1'b1;
        end else if (s.gt_clear) begin
            alarm_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || !alarm_reg || s.fault) begin
            alarm_mute_reg <= 1'b0;
        end else if (short_rel && zst_reg != ZERO_ARMED) begin
            alarm_mute_reg <= ~alarm_mute_reg;
        end
    end

    // alarm test lasts while the button stays down
    always_ff @(posedge clk) begin
        if (rst || !btn_deb_reg) begin
            test_reg <= 1'b0;
        end else if (long_hit && s.gt_clear && !s.fault) begin
            test_reg <= 1'b1;
        end
    end

    // dry-filter message; after a clear, humid cannot raise it again until the pump starts again
    always_ff @(posedge clk) begin
        if (rst || !ctrl_opt_reg) begin
            dry_msg_reg <= 1'b0;
            dry_clr_reg <= 1'b0;
            dry_mute_reg <= 1'b0;
        end else begin
            if (dry_clear) begin
                dry_clr_reg <= 1'b1;
            end else if (pump_rise) begin
                dry_clr_reg <= 1'b0;
            end
            if (dry_clear) begin
                dry_msg_reg <= 1'b0;
            end else if (s.humid && !dry_clr_reg) begin
                dry_msg_reg <= 1'b1;
            end
            if (!dry_msg_reg || dry_clear) begin
                dry_mute_reg <= 1'b0;
            end else if (short_rel && !alarm_reg && !s.fault) begin
                dry_mute_reg <= 1'b1;
            end
        end
    end

    // zero-point sequence: mid hold release arms, next short press captures
    assign zero_take = (zst_reg == ZERO_ARMED) && short_rel && !s.fault;
    always_ff @(posedge clk) begin
        if (rst) begin
            zst_reg <= ZERO_IDLE;
            zero_point_reg <= 12'h000;
        end else begin
            case (zst_reg)
                ZERO_IDLE: begin
                    if (mid_rel && alarm_reg && !dry_msg_reg && !s.fault) begin
                        zst_reg <= ZERO_ARMED;
                    end
                end
                ZERO_ARMED: begin
                    if (s.fault || long_hit) begin
                        zst_reg <= ZERO_IDLE;
                    end else if (zero_take) begin
                        zero_point_reg <= zero_s2_reg;
                        zst_reg <= ZERO_LOCKED;
                    end
                end
                ZERO_LOCKED: begin
                    if (s.ge_stop) begin
                        zst_reg <= ZERO_IDLE;
                    end
                end
                default: zst_reg <= ZERO_IDLE;
            endcase
        end
    end

    // idle time between refills gives the tightness grade
    always_ff @(posedge clk) begin
        if (rst) begin
            step_tmr_reg <= 32'h0;
            step_lvl_reg <= 2'h0;
            leak_lvl_reg <= 2'h0;
            refill_ok_reg <= 1'b0;
        end else begin
            if (pump_reg) begin
                step_tmr_reg <= 32'h0;
                step_lvl_reg <= 2'h0;
            end else if (step_tmr_reg == 32'(P_IDLE_STEP - 1)) begin
                step_tmr_reg <= 32'h0;
                if (step_lvl_reg != 2'h3) begin
                    step_lvl_reg <= step_lvl_reg + 2'h1;
                end
            end else begin
                step_tmr_reg <= step_tmr_reg + 32'h1;
            end
            if (pump_rise) begin
                leak_lvl_reg <= step_lvl_reg;
            end
            if (!pump_reg && pump_q_reg && !alarm_reg && !s.fault) begin
                refill_ok_reg <= 1'b1;
            end
        end
    end

    // flasher shared by zero confirmation and leak result
    assign leak_ask = mid_rel && !alarm_reg && !dry_msg_reg && !s.fault;
    assign fl_load = zero_take || leak_ask;
    always_comb begin
        if (zero_take) begin
            fl_n = ZERO_FLASHES;
        end else if (refill_ok_reg) begin
            fl_n = {1'b0, leak_lvl_reg} + 3'h1;
        end else begin
            fl_n = 3'h0;
        end
    end
    assign fl_active = (fl_cnt_reg != 3'h0);

    always_ff @(posedge clk) begin
        if (rst) begin
            fl_cnt_reg <= 3'h0;
            fl_tmr_reg <= 32'h0;
            fl_on_reg <= 1'b0;
            fl_buzz_reg <= 1'b0;
        end else if (fl_load) begin
            fl_cnt_reg <= fl_n;
            fl_tmr_reg <= 32'h0;
            fl_on_reg <= (fl_n != 3'h0);
            fl_buzz_reg <= zero_take;
        end else if (fl_active) begin
            if (fl_tmr_reg == 32'(P_PULSE - 1)) begin
                fl_tmr_reg <= 32'h0;
                if (fl_on_reg) begin
                    fl_on_reg <= 1'b0;
                    fl_cnt_reg <= fl_cnt_reg - 3'h1;
                end else begin
                    fl_on_reg <= 1'b1;
                end
            end else begin
                fl_tmr_reg <= fl_tmr_reg + 32'h1;
            end
        end
    end

    // indicator decisions, highest priority first
    always_comb begin
        if (s.fault || test_reg) begin
            alarm_lamp_next = 1'b1;
        end else if (fl_active) begin
            alarm_lamp_next = fl_on_reg;
        end else if (held_mid && !dry_msg_reg) begin
            alarm_lamp_next = alarm_reg ? slow_reg : fast_reg;
        end else if (alarm_reg) begin
            alarm_lamp_next = alarm_mute_reg ? slow_reg : 1'b1;
        end else begin
            alarm_lamp_next = dry_msg_reg && slow_reg;
        end
        if (s.fault) begin
            dry_lamp_next = 1'b1;
        end else if (!dry_msg_reg) begin
            dry_lamp_next = 1'b0;
        end else if (held_mid) begin
            dry_lamp_next = fast_reg;
        end else begin
            dry_lamp_next = !alarm_reg && !slow_reg;
        end
        buzzer_next = s.fault || test_reg || (fl_active && fl_on_reg && fl_buzz_reg)
                      || (alarm_reg && !alarm_mute_reg)
                      || (dry_msg_reg && !alarm_reg && !dry_mute_reg);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            op_lamp <= 1'b1;
            alarm_lamp <= 1'b0;
            dry_lamp <= 1'b0;
            buzzer <= 1'b0;
            remote_alarm <= 1'b0;
            dry_relay <= 1'b0;
            pump_on <= 1'b0;
        end else begin
            op_lamp <= 1'b1;
            alarm_lamp <= alarm_lamp_next;
            dry_lamp <= dry_lamp_next;
            buzzer <= buzzer_next;
            remote_alarm <= alarm_reg || s.fault;
            dry_relay <= dry_msg_reg;
            pump_on <= pump_reg;
        end
    end

    // apb slave: zero wait states, read data captured in the setup cycle, write data in the access cycle
    always_comb begin
        status = 32'h0;
        status[ST_PUMP] = pump_reg;
        status[ST_ALARM] = alarm_reg;
        status[ST_ALARM_MUTE] = alarm_mute_reg;
        status[ST_DRY] = dry_msg_reg;
        status[ST_DRY_MUTE] = dry_mute_reg;
        status[ST_TEST] = test_reg;
        status[ST_ZERO_LOCK] = (zst_reg == ZERO_LOCKED);
        status[ST_ZERO_ARMED] = (zst_reg == ZERO_ARMED);
        status[ST_REFILL_OK] = refill_ok_reg;
        status[ST_FAULT] = s.fault;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_opt_reg <= CTRL_RESET;
            prdata <= 32'h0;
        end else begin
            if (psel && penable && pwrite && paddr == REG_CTRL) begin
                ctrl_opt_reg <= pwdata[CTRL_OPT_BIT];
            end
            if (psel && !penable) begin
                if (pwrite) begin
                    prdata <= 32'h0;
                end else if (paddr == REG_CTRL) begin
                    prdata <= {31'h0, ctrl_opt_reg};
                end else if (paddr == REG_STATUS) begin
                    prdata <= status;
                end else if (paddr == REG_ZERO) begin
                    prdata <= {20'h0, zero_point_reg};
                end else if (paddr == REG_LEAK) begin
                    prdata <= {29'h0, refill_ok_reg, leak_lvl_reg};
                end else begin
                    prdata <= 32'h0;
                end
            end
        end
    end

    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_ok(paddr);

    sequence seq_zero_done;
        fl_cnt_reg == ZERO_FLASHES && fl_buzz_reg && zst_reg == ZERO_LOCKED;
    endsequence

    a_pump_stop: assert property (@(posedge clk) disable iff (rst)
        s.ge_stop |=> !pump_reg ##1 !pump_on) else $error("pump not stopped");
    a_pump_start: assert property (@(posedge clk) disable iff (rst)
        s.le_start && !s.ge_stop |=> pump_reg ##1 pump_on) else $error("pump not started");
    a_alarm_raise: assert property (@(posedge clk) disable iff (rst)
        s.le_alarm |=> alarm_reg ##1 remote_alarm) else $error("alarm not raised");
    a_dry_relay: assert property (@(posedge clk) disable iff (rst)
        dry_msg_reg |=> dry_relay) else $error("relay not closed");
    a_mute_toggle: assert property (@(posedge clk) disable iff (rst)
        short_rel && alarm_reg && !s.fault && zst_reg == ZERO_IDLE
        |=> alarm_mute_reg != $past(alarm_mute_reg)) else $error("mute not toggled");
    a_fault_loud: assert property (@(posedge clk) disable iff (rst)
        s.fault |=> buzzer && !alarm_mute_reg) else $error("fault buzzer off");
    a_test_end: assert property (@(posedge clk) disable iff (rst)
        test_reg && !btn_deb_reg |=> !test_reg) else $error("test outlived press");
    a_test_refused: assert property (@(posedge clk) disable iff (rst)
        long_hit && !s.gt_clear && !test_reg |=> !test_reg) else $error("test accepted");
    a_dry_clear: assert property (@(posedge clk) disable iff (rst)
        dry_clear |=> !dry_msg_reg && dry_clr_reg) else $error("dry not cleared");
    a_zero_confirm: assert property (@(posedge clk) disable iff (rst)
        zero_take |=> seq_zero_done) else $error("zero not confirmed");
    a_zero_block: assert property (@(posedge clk) disable iff (rst)
        zst_reg == ZERO_LOCKED && !s.ge_stop |=> zst_reg == ZERO_LOCKED) else $error("zero reopened");
    a_leak_valid: assert property (@(posedge clk) disable iff (rst)
        leak_ask && !refill_ok_reg |=> !fl_active) else $error("invalid leak shown");
    a_op_lamp: assert property (@(posedge clk) disable iff (rst)
        1'b1 |=> op_lamp) else $error("operation lamp dark");
endmodule

`default_nettype wire

//--- dv/lai_plant.sv
`timescale 1ns/1ps
`default_nettype none

// tank model: a working pump adds 4 per cycle, the leak drains a set rate
module lai_plant
    import lai_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // plant controls
    input wire logic pump_on,
    input wire logic pump_ok,
    input wire logic [2:0] leak,
    input wire logic humid,
    input wire logic fault,
    // sensor view
    output var lai_sense_type sense,
    output logic [11:0] level
);
    always_ff @(posedge clk) begin
        if (rst) begin
            level <= 12'h0be;
        end else if (pump_on && pump_ok) begin
            level <= level + 12'h004;
        end else if (level > 12'(leak)) begin
            level <= level - 12'(leak);
        end
    end

    // stop 200, start 180, clear 120, alarm 100
    always_comb begin
        sense.le_start = level <= 12'h0b4;
        sense.ge_stop = level >= 12'h0c8;
        sense.le_alarm = level <= 12'h064;
        sense.gt_clear = level > 12'h078;
        sense.humid = humid;
        sense.fault = fault;
    end
endmodule

`default_nettype wire

//--- dv/tb_leak_alarm_indicator_control.sv
`timescale 1ns/1ps
`default_nettype none

module tb_leak_alarm_indicator_control;
    import lai_pkg::*;
    localparam int MID = 40;
    localparam int LONG = 80;
    logic clk, rst, psel, penable, pwrite, pready, pslverr, er;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pump_ok, humid, fault, button_n;
    logic [2:0] leak;
    logic [11:0] zero_level, level;
    lai_sense_type sense;
    logic pump_on, op_lamp, alarm_lamp, dry_lamp, buzzer, remote_alarm, dry_relay;
    int n_fail, checks, cnt;

    lai_ctrl #(.P_HOLD_MID(MID), .P_HOLD_LONG(LONG), .P_DEBOUNCE(4), .P_BLINK(4),
        .P_PULSE(3), .P_IDLE_STEP(20)) u_dut (.clk(clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .sense(sense),
        .zero_level(zero_level), .button_n(button_n), .pump_on(pump_on),
        .op_lamp(op_lamp), .alarm_lamp(alarm_lamp), .dry_lamp(dry_lamp),
        .buzzer(buzzer), .remote_alarm(remote_alarm), .dry_relay(dry_relay));
    lai_plant u_plant (.clk(clk), .rst(rst), .pump_on(pump_on), .pump_ok(pump_ok),
        .leak(leak), .humid(humid), .fault(fault), .sense(sense), .level(level));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic stop_test;
        $display("counts: checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask

    // setup then access, held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int t;
        t = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            t++;
        end while (pready !== 1'b1 && t < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic hold(input int n);
        @(posedge clk);
        button_n <= 1'b0;
        repeat (n) @(posedge clk);
        button_n <= 1'b1;
        repeat (12) @(posedge clk);
    endtask

    function automatic logic pick(input int s);
        case (s)
            0: return pump_on;
            1: return alarm_lamp;
            2: return dry_relay;
            3: return dry_lamp;
            default: return buzzer;
        endcase
    endfunction

    task automatic wait_on(input int s, input logic v);
        int t;
        t = 0;
        while (pick(s) !== v && t < 3000) begin
            @(posedge clk);
            t++;
        end
        chk(pick(s), v, "signal never reached level");
    endtask

    // counts rising edges over n cycles, optionally with a short press at the start
    task automatic edges(input int s, input int n, input logic press);
        logic p;
        p = pick(s);
        cnt = 0;
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            if (press && i == 0) button_n <= 1'b0;
            if (press && i == 10) button_n <= 1'b1;
            #1;
            if (pick(s) === 1'b1 && p !== 1'b1) cnt++;
            p = pick(s);
        end
    endtask

    task automatic lower(input logic [11:0] to);
        int t;
        t = 0;
        @(posedge clk);
        pump_ok <= 1'b0;
        leak <= 3'h1;
        while (level > to && t < 400) begin
            @(posedge clk);
            t++;
        end
        leak <= 3'h0;
    endtask

    task automatic t_reset;
        chk(op_lamp, 1, "op lamp after reset");
        chk(pready, 1, "no wait states");
        chk({pump_on, alarm_lamp, dry_lamp, buzzer, dry_relay}, 0, "outputs idle");
        apb(0, REG_CTRL, 0);
        chk(rd, 0, "ctrl reset value");
        apb(0, REG_LEAK, 0);
        chk(rd[LEAK_VALID_BIT], 0, "no refill yet");
        apb(1, 8'h10, 32'h5);
        chk(er, 1, "unmapped refused");
        $display("test reset done");
    endtask

    task automatic t_refill;
        leak <= 3'h1;
        wait_on(0, 1);
        chk(level <= 12'h0b4, 1, "pump on at start level");
        wait_on(0, 0);
        chk(level >= 12'h0c8, 1, "pump off at stop level");
        apb(0, REG_LEAK, 0);
        chk(rd[LEAK_VALID_BIT], 1, "refill seen");
        hold(MID + 10);
        edges(1, 400, 0);
        chk(cnt >= 1 && cnt <= 4, 1, "leak grade flashes");
        leak <= 3'h0;
        hold(10);
        chk({alarm_lamp, buzzer}, 0, "mute ignored in normal");
        $display("test refill done");
    endtask

    task automatic t_test;
        @(posedge clk);
        button_n <= 1'b0;
        repeat (LONG + 20) @(posedge clk);
        chk({buzzer, remote_alarm}, 2'b10, "alarm test, remote untouched");
        button_n <= 1'b1;
        repeat (12) @(posedge clk);
        chk(buzzer, 0, "test ends on release");
        lower(12'h073);
        hold(LONG + 20);
        chk({alarm_lamp, buzzer}, 0, "test refused below clear");
        $display("test alarm test done");
    endtask

    task automatic t_alarm;
        lower(12'h05a);
        wait_on(1, 1);
        chk({buzzer, remote_alarm, op_lamp}, 3'h7, "alarm raised");
        hold(10);
        chk(buzzer, 0, "mute silences");
        edges(1, 40, 0);
        chk(cnt >= 1, 1, "lamp blinks when muted");
        chk(remote_alarm, 1, "remote kept");
        hold(10);
        chk(buzzer, 1, "second press restores");
        fault <= 1'b1;
        hold(10);
        chk(buzzer, 1, "fault not mutable");
        fault <= 1'b0;
        $display("test alarm done");
    endtask

    task automatic t_zero;
        zero_level <= 12'h5a3;
        hold(10);
        hold(MID + 10);
        apb(0, REG_STATUS, 0);
        chk(rd[ST_ZERO_ARMED], 1, "zero armed");
        edges(4, 60, 1);
        chk(cnt, 3, "three confirm flashes");
        apb(0, REG_ZERO, 0);
        chk(rd[11:0], 12'h5a3, "zero captured");
        zero_level <= 12'h111;
        hold(MID + 10);
        hold(10);
        apb(0, REG_ZERO, 0);
        chk(rd[11:0], 12'h5a3, "repeat blocked");
        pump_ok <= 1'b1;
        wait_on(0, 1);
        wait_on(0, 0);
        apb(0, REG_STATUS, 0);
        chk(rd[ST_ZERO_LOCK], 0, "lock freed at stop level");
        $display("test zero done");
    endtask

    task automatic t_dry;
        apb(1, REG_CTRL, 32'h1);
        humid <= 1'b1;
        wait_on(2, 1);
        chk(buzzer, 1, "dry buzzer");
        hold(10);
        chk(buzzer, 0, "dry muted");
        edges(3, 40, 0);
        chk(cnt >= 1, 1, "lamps keep blinking");
        hold(MID + 10);
        chk(dry_relay, 0, "message cleared");
        leak <= 3'h1;
        wait_on(2, 1);
        humid <= 1'b0;
        leak <= 3'h0;
        $display("test dry done");
    endtask

    initial begin
        n_fail = 0;
        checks = 0;
        rst = 1'b1;
        {psel, penable, pwrite, humid, fault} = '0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pump_ok = 1'b1;
        leak = 3'h0;
        button_n = 1'b1;
        zero_level = 12'h000;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_refill();
        t_test();
        t_alarm();
        t_zero();
        t_dry();
        stop_test();
    end

    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        $display("mismatch at %0t: watchdog expired", $time);
        stop_test();
    end
endmodule

`default_nettype wire
